// file: dem_consts.svh
// Constants of the drive error monitor: object indexes, bit positions, reset values and emergency codes.
// How it works
// - Summary byte shows only generic and communication bits; all other bits stay zero.
// - Every emergency message carries the current summary error byte.
// - A fault flag reads 1 while flagged; clears when condition ends or on fault reset.
// - A flag rising with its mask bit set queues a message with its code.
// - A flag falling with its mask bit set queues an error-cleared message.
// - Masked-off flags send nothing; mask shares the layout and resets to all ones.
// - Bit 15 follows the enable input: set while disabled, clear while enabled.
// - Bit 14 warns of command errors with homing, mode or I/O line codes.
// - Bit 14 also flags busy function calls, with status bit 7, and mode updates.
// - Bits 13 and 12 latch under- and over-voltage trips until fault reset.
// - Bits 11 and 10 latch drive and motor over-temperature until fault reset.
// - Bits 9 and 8 latch overload-integral and over-current trips until fault reset.
// - Bit 1 latches short-circuit trips until fault reset.
// - Bits 7 and 6 follow the negative and positive limit inputs.
// - Bits 5, 4 and 3 latch wrap-around, communication and control errors.
// - Bit 2 is set while the stored setup data is invalid or absent.
// - Bit 0 latches link errors; fault reset or link clear-error clears it.
`ifndef DEM_CONSTS_SVH
`define DEM_CONSTS_SVH
`define DEM_IDX_SUMMARY   16'h1001
`define DEM_IDX_FLAGS     16'h2000
`define DEM_IDX_MASK      16'h2001
`define DEM_FLAGS_RST     16'h0000
`define DEM_MASK_RST      16'hffff
`define DEM_LATCH_BITS    16'h7f3b
`define DEM_SUM_GENERIC   0
`define DEM_SUM_COMM      4
`define DEM_B_ENABLE      15
`define DEM_B_CMD         14
`define DEM_B_UNDERVOLT   13
`define DEM_B_OVERVOLT    12
`define DEM_B_DRIVETEMP   11
`define DEM_B_MOTORTEMP   10
`define DEM_B_OVERLOAD    9
`define DEM_B_OVERCURR    8
`define DEM_B_NEGLIMIT    7
`define DEM_B_POSLIMIT    6
`define DEM_B_WRAP        5
`define DEM_B_COMM        4
`define DEM_B_CONTROL     3
`define DEM_B_SETUP       2
`define DEM_B_SHORT       1
`define DEM_B_LINK        0
`define DEM_CODE_HOMING   16'hff03
`define DEM_CODE_MODE     16'hff04
`define DEM_CODE_IO       16'hff05
`define DEM_CODE_BASE     16'hff10
`define DEM_CODE_CLEARED  16'h0000
`endif

// file: dem_pkg.sv
// Types shared by the drive error monitor.
package dem_pkg;
   typedef enum logic [1:0] {CMD_HOMING, CMD_MODE, CMD_IO} dem_cmd_err_e;
   typedef enum logic {EM_IDLE, EM_SEND} dem_emcy_state_e;
endpackage

// file: dem_input_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module dem_input_sync #(
   parameter int         W       = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Pins and filtered levels
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] level
);
   logic [W-1:0] stage1Reg;
   logic [W-1:0] stage2Reg;
   logic [W-1:0] stage3Reg;
   logic [W-1:0] levelReg;
   logic [W-1:0] level_next;

   // A single-cycle glitch in stage two never reaches the level.
   always_comb begin
      level_next = (levelReg & (stage2Reg ^ stage3Reg)) | (stage2Reg & ~(stage2Reg ^ stage3Reg));
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // Stages start at the idle level too, so no false edge follows reset.
         stage1Reg <= RST_VAL;
         stage2Reg <= RST_VAL;
         stage3Reg <= RST_VAL;
         levelReg  <= RST_VAL;
      end else begin
         stage1Reg <= pinIn;
         stage2Reg <= stage1Reg;
         stage3Reg <= stage2Reg;
         levelReg  <= level_next;
      end
   end

   assign level = levelReg;
endmodule
`default_nettype wire

// file: drive_error_monitor.sv
// Drive error monitor: fault flags, notify mask, summary byte and emergency message queue.
`timescale 1ns/1ps
`default_nettype none
`include "dem_consts.svh"
module dem_drive_error_monitor (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // Object dictionary access
   input  wire logic [15:0]           objIndex,
   input  wire logic                  objWrite,
   input  wire logic                  objRead,
   input  wire logic [15:0]           objWdata,
   output logic      [15:0]           objRdata,
   output logic                       objAck,
   output logic                       objErr,
   // Pins from outside the clock domain
   input  wire logic                  enableIn,
   input  wire logic                  negLimitIn,
   input  wire logic                  posLimitIn,
   input  wire logic                  setupInvalidIn,
   // Protection trips, one-cycle pulses
   input  wire logic                  underVoltTrip,
   input  wire logic                  overVoltTrip,
   input  wire logic                  driveTempTrip,
   input  wire logic                  motorTempTrip,
   input  wire logic                  overloadIntegralTrip,
   input  wire logic                  overCurrentTrip,
   input  wire logic                  shortCircuitTrip,
   input  wire logic                  positionWrapTrip,
   input  wire logic                  commErrorTrip,
   input  wire logic                  controlErrorTrip,
   input  wire logic                  linkErrorEvt,
   // Commands and command checks, one-cycle pulses
   input  wire logic                  faultReset,
   input  wire logic                  linkClearError,
   input  wire logic                  cmdErrPulse,
   input  wire dem_pkg::dem_cmd_err_e cmdErrCode,
   input  wire logic                  fnBusyCall,
   input  wire logic                  modeUpdInTransition,
   // Emergency messages
   output logic                       emcyValid,
   input  wire logic                  emcyReady,
   output logic      [15:0]           emcyCode,
   output logic      [7:0]            emcyErrByte,
   // Status
   output logic      [15:0]           motionFaultFlags,
   output logic      [7:0]            summaryErrorByte,
   output logic                       callWarnStatus
);
   import dem_pkg::*;

   function automatic logic [1:0] decodeIndex(input logic [15:0] idx);
      if (idx == `DEM_IDX_SUMMARY) begin
         decodeIndex = 2'h1;
      end else if (idx == `DEM_IDX_FLAGS) begin
         decodeIndex = 2'h2;
      end else if (idx == `DEM_IDX_MASK) begin
         decodeIndex = 2'h3;
      end else begin
         decodeIndex = 2'h0;
      end
   endfunction

   logic [3:0] pinLevel;

   dem_input_sync #(
      .W       (4),
      .RST_VAL (4'h1)
   ) u_sync (
      .clk   (clk),
      .rst   (rst),
      .pinIn ({setupInvalidIn, posLimitIn, negLimitIn, enableIn}),
      .level (pinLevel)
   );

   logic enableOk;
   logic negLimit;
   logic posLimit;
   logic setupBad;
   assign enableOk = pinLevel[0];
   assign negLimit = pinLevel[1];
   assign posLimit = pinLevel[2];
   assign setupBad = pinLevel[3];

   // Fault flags, mask, summary byte and command-error state.
   logic [15:0] flagsReg;
   logic [15:0] flags_next;
   logic [15:0] maskReg;
   logic [15:0] mask_next;
   logic [7:0]  sumReg;
   logic [7:0]  sum_next;
   logic        callWarnReg;
   logic        callWarn_next;
   logic [15:0] cmdCodeReg;
   logic [15:0] cmdCode_next;
   logic [15:0] latchSet;
   logic [15:0] latchClr;

   always_comb begin
      latchSet = '0;
      latchSet[`DEM_B_CMD]       = cmdErrPulse | fnBusyCall | modeUpdInTransition;
      latchSet[`DEM_B_UNDERVOLT] = underVoltTrip;
      latchSet[`DEM_B_OVERVOLT]  = overVoltTrip;
      latchSet[`DEM_B_DRIVETEMP] = driveTempTrip;
      latchSet[`DEM_B_MOTORTEMP] = motorTempTrip;
      latchSet[`DEM_B_OVERLOAD]  = overloadIntegralTrip;
      latchSet[`DEM_B_OVERCURR]  = overCurrentTrip;
      latchSet[`DEM_B_WRAP]      = positionWrapTrip;
      latchSet[`DEM_B_COMM]      = commErrorTrip;
      latchSet[`DEM_B_CONTROL]   = controlErrorTrip;
      latchSet[`DEM_B_SHORT]     = shortCircuitTrip;
      latchSet[`DEM_B_LINK]      = linkErrorEvt;
      latchClr = faultReset ? `DEM_LATCH_BITS : 16'h0000;
      latchClr[`DEM_B_LINK] = faultReset | linkClearError;
      // A trip in the same cycle as the reset wins, so no event is lost.
      flags_next = ((flagsReg & ~latchClr) | latchSet) & `DEM_LATCH_BITS;
      flags_next[`DEM_B_ENABLE]   = ~enableOk;
      flags_next[`DEM_B_NEGLIMIT] = negLimit;
      flags_next[`DEM_B_POSLIMIT] = posLimit;
      flags_next[`DEM_B_SETUP]    = setupBad;
      sum_next = 8'h00;
      sum_next[`DEM_SUM_GENERIC] = |flags_next;
      sum_next[`DEM_SUM_COMM] = flags_next[`DEM_B_COMM] | flags_next[`DEM_B_LINK];
      callWarn_next = fnBusyCall | (callWarnReg & ~faultReset);
      cmdCode_next = cmdCodeReg;
      if (cmdErrPulse) begin
         case (cmdErrCode)
            CMD_HOMING: cmdCode_next = `DEM_CODE_HOMING;
            CMD_MODE:   cmdCode_next = `DEM_CODE_MODE;
            default:    cmdCode_next = `DEM_CODE_IO;
         endcase
      end else if (fnBusyCall | modeUpdInTransition) begin
         cmdCode_next = `DEM_CODE_BASE + 16'(`DEM_B_CMD);
      end
      mask_next = maskReg;
      if (objWrite && decodeIndex(objIndex) == 2'h3) begin
         mask_next = objWdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flagsReg    <= `DEM_FLAGS_RST;
         maskReg     <= `DEM_MASK_RST;
         sumReg      <= 8'h00;
         callWarnReg <= 1'b0;
         cmdCodeReg  <= `DEM_CODE_BASE;
      end else begin
         flagsReg    <= flags_next;
         maskReg     <= mask_next;
         sumReg      <= sum_next;
         callWarnReg <= callWarn_next;
         cmdCodeReg  <= cmdCode_next;
      end
   end

   // Object access answers one cycle after the request.
   logic [15:0] rdReg;
   logic [15:0] rd_next;
   logic        ackReg;
   logic        ack_next;
   logic        errReg;
   logic        err_next;

   always_comb begin
      rd_next  = rdReg;
      ack_next = objRead | objWrite;
      err_next = 1'b0;
      if (objRead) begin
         case (decodeIndex(objIndex))
            2'h1:    rd_next = {8'h00, sumReg};
            2'h2:    rd_next = flagsReg;
            2'h3:    rd_next = maskReg;
            default: rd_next = 16'h0000;
         endcase
      end
      // Writes to read-only objects are refused, as are unknown indexes.
      if ((objRead | objWrite) && decodeIndex(objIndex) == 2'h0) begin
         err_next = 1'b1;
      end else if (objWrite && decodeIndex(objIndex) != 2'h3) begin
         err_next = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdReg  <= 16'h0000;
         ackReg <= 1'b0;
         errReg <= 1'b0;
      end else begin
         rdReg  <= rd_next;
         ackReg <= ack_next;
         errReg <= err_next;
      end
   end

   // Emergency queue: one pending rise and one pending fall per flag.
   dem_emcy_state_e emState;
   dem_emcy_state_e emState_next;
   logic [15:0] pendRiseReg;
   logic [15:0] pendRise_next;
   logic [15:0] pendFallReg;
   logic [15:0] pendFall_next;
   logic        validReg;
   logic        valid_next;
   logic [15:0] codeReg;
   logic [15:0] code_next;
   logic [7:0]  byteReg;
   logic [7:0]  byte_next;
   logic        found;
   logic [3:0]  pick;

   always_comb begin
      found = 1'b0;
      pick  = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (!found && (pendRiseReg[i] | pendFallReg[i])) begin
            found = 1'b1;
            pick  = 4'(i);
         end
      end
      pendRise_next = pendRiseReg;
      pendFall_next = pendFallReg;
      emState_next  = emState;
      valid_next    = validReg;
      code_next     = codeReg;
      byte_next     = byteReg;
      case (emState)
         EM_IDLE: begin
            if (found) begin
               emState_next = EM_SEND;
               valid_next   = 1'b1;
               byte_next    = sumReg;
               if (pendRiseReg[pick]) begin
                  pendRise_next[pick] = 1'b0;
                  if (pick == 4'(`DEM_B_CMD)) begin
                     code_next = cmdCodeReg;
                  end else begin
                     code_next = `DEM_CODE_BASE + {12'h000, pick};
                  end
               end else begin
                  pendFall_next[pick] = 1'b0;
                  code_next = `DEM_CODE_CLEARED;
               end
            end
         end
         default: begin
            if (emcyReady) begin
               emState_next = EM_IDLE;
               valid_next   = 1'b0;
            end
         end
      endcase
      // New edges are added after the take, so an edge is never dropped.
      pendRise_next = pendRise_next | (flags_next & ~flagsReg & maskReg);
      pendFall_next = pendFall_next | (~flags_next & flagsReg & maskReg);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         emState     <= EM_IDLE;
         pendRiseReg <= 16'h0000;
         pendFallReg <= 16'h0000;
         validReg    <= 1'b0;
         codeReg     <= 16'h0000;
         byteReg     <= 8'h00;
      end else begin
         emState     <= emState_next;
         pendRiseReg <= pendRise_next;
         pendFallReg <= pendFall_next;
         validReg    <= valid_next;
         codeReg     <= code_next;
         byteReg     <= byte_next;
      end
   end

   assign objRdata         = rdReg;
   assign objAck           = ackReg;
   assign objErr           = errReg;
   assign emcyValid        = validReg;
   assign emcyCode         = codeReg;
   assign emcyErrByte      = byteReg;
   assign motionFaultFlags = flagsReg;
   assign summaryErrorByte = sumReg;
   assign callWarnStatus   = callWarnReg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_offer;
      emcyValid && !emcyReady;
   endsequence

   sequence s_overcurr_rise;
      $rose(flagsReg[`DEM_B_OVERCURR]) && $past(maskReg[`DEM_B_OVERCURR]);
   endsequence

   a_summary_layout: assert property (
      (sumReg[7:5] == 3'h0) && (sumReg[3:1] == 3'h0) && (sumReg[0] == (|flagsReg))
      && (sumReg[4] == (flagsReg[`DEM_B_COMM] | flagsReg[`DEM_B_LINK])))
      else $error("summary byte has wrong bits");

   a_emcy_byte: assert property ($rose(emcyValid) |-> emcyErrByte == $past(sumReg))
      else $error("emergency message lacks summary byte");

   a_fault_reset: assert property (
      $past(faultReset) && !$past(overCurrentTrip | underVoltTrip | shortCircuitTrip)
      |-> !flagsReg[`DEM_B_OVERCURR] && !flagsReg[`DEM_B_UNDERVOLT] && !flagsReg[`DEM_B_SHORT])
      else $error("latched flag survived fault reset");

   a_rise_queue: assert property (s_overcurr_rise |-> pendRiseReg[`DEM_B_OVERCURR])
      else $error("masked-in rise not queued");

   a_fall_queue: assert property (
      $fell(flagsReg[`DEM_B_NEGLIMIT]) && $past(maskReg[`DEM_B_NEGLIMIT]) |-> pendFallReg[`DEM_B_NEGLIMIT])
      else $error("masked-in fall not queued");

   a_mask_block: assert property (
      $rose(flagsReg[`DEM_B_OVERCURR]) && !$past(maskReg[`DEM_B_OVERCURR]) && !$past(pendRiseReg[`DEM_B_OVERCURR])
      |-> !pendRiseReg[`DEM_B_OVERCURR])
      else $error("masked-out rise queued");

   a_enable_follow: assert property (flagsReg[`DEM_B_ENABLE] == !$past(enableOk))
      else $error("enable flag does not follow input");

   a_busy_call: assert property ($past(fnBusyCall) |-> flagsReg[`DEM_B_CMD] && callWarnReg)
      else $error("busy call not flagged");

   a_limit_follow: assert property (
      flagsReg[`DEM_B_POSLIMIT] == $past(posLimit) && flagsReg[`DEM_B_NEGLIMIT] == $past(negLimit))
      else $error("limit flags do not follow inputs");

   a_link_clear: assert property ($past(linkClearError && !linkErrorEvt) |-> !flagsReg[`DEM_B_LINK])
      else $error("link error not cleared");

   a_send_hold: assert property (s_offer |=> emcyValid && $stable(emcyCode) && $stable(emcyErrByte))
      else $error("emergency message dropped before taken");

   a_ascend_order: assert property (
      $rose(emcyValid) && $past(pendRiseReg[`DEM_B_LINK]) |-> emcyCode == `DEM_CODE_BASE)
      else $error("queue not issued in ascending order");
endmodule
`default_nettype wire

// file: dem_fieldbus_master.sv
// Fieldbus master model that takes emergency messages after a programmable stall.
`timescale 1ns/1ps
`default_nettype none
module dem_fieldbus_master (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Emergency message channel
   input  wire logic        emcyValid,
   input  wire logic [15:0] emcyCode,
   input  wire logic [7:0]  emcyErrByte,
   output logic             emcyReady,
   // Stall setting and capture of the last message taken
   input  wire logic [3:0]  stallCycles,
   output logic [7:0]       msgCount,
   output logic [15:0]      lastCode,
   output logic [7:0]       lastByte
);
   logic [3:0] waitCnt;

   // A slow master keeps ready low for a while, so the drive must hold its message standing meanwhile.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         emcyReady <= 1'b0;
         waitCnt   <= 4'h0;
         msgCount  <= 8'h00;
         lastCode  <= 16'h0000;
         lastByte  <= 8'h00;
      end else if (emcyValid && emcyReady) begin
         msgCount  <= msgCount + 8'h01;
         lastCode  <= emcyCode;
         lastByte  <= emcyErrByte;
         emcyReady <= 1'b0;
         waitCnt   <= 4'h0;
      end else if (emcyValid) begin
         if (waitCnt >= stallCycles) begin
            emcyReady <= 1'b1;
         end else begin
            waitCnt <= waitCnt + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench of the drive error monitor.
`timescale 1ns/1ps
`default_nettype none
`include "dem_consts.svh"
module tb_top;
   import dem_pkg::*;
   typedef struct packed {
      logic [15:0] trip;
      logic [1:0]  cmd;
      logic [7:0]  sum;
      logic [15:0] code;
   } dem_row_s;
   localparam logic [4:0] FR = 5'h01, LC = 5'h02, CE = 5'h04, FB = 5'h08, MU = 5'h10;
   logic             clk, rst, objWrite, objRead, objAck, objErr, emcyValid, emcyReady, callWarnStatus;
   logic             enableIn, negLimitIn, posLimitIn, setupInvalidIn;
   logic [15:0]      objIndex, objWdata, objRdata, tripVec, emcyCode, motionFaultFlags, lastCode;
   logic [7:0]       emcyErrByte, summaryErrorByte, msgCount, lastByte, seenCount;
   logic [4:0]       ctlVec;
   logic [3:0]       stallCycles;
   dem_cmd_err_e     cmdErrCode;
   int               err_total, comparisons;
   // Each row: trip vector (bit 14 means a command check), command code, summary and first message code.
   dem_row_s rows [14] = '{
      '{16'h2000, 2'h3, 8'h01, 16'hff1d}, '{16'h1000, 2'h3, 8'h01, 16'hff1c}, '{16'h0800, 2'h3, 8'h01, 16'hff1b},
      '{16'h0400, 2'h3, 8'h01, 16'hff1a}, '{16'h0200, 2'h3, 8'h01, 16'hff19}, '{16'h0100, 2'h3, 8'h01, 16'hff18},
      '{16'h0020, 2'h3, 8'h01, 16'hff15}, '{16'h0010, 2'h3, 8'h11, 16'hff14}, '{16'h0008, 2'h3, 8'h01, 16'hff13},
      '{16'h0002, 2'h3, 8'h01, 16'hff11}, '{16'h0001, 2'h3, 8'h11, 16'hff10}, '{16'h4000, 2'h0, 8'h01, 16'hff03},
      '{16'h4000, 2'h1, 8'h01, 16'hff04}, '{16'h4000, 2'h2, 8'h01, 16'hff05}};

   dem_drive_error_monitor dut_u (
      .clk(clk), .rst(rst), .objIndex(objIndex), .objWrite(objWrite), .objRead(objRead), .objWdata(objWdata),
      .objRdata(objRdata), .objAck(objAck), .objErr(objErr), .enableIn(enableIn), .negLimitIn(negLimitIn),
      .posLimitIn(posLimitIn), .setupInvalidIn(setupInvalidIn), .underVoltTrip(tripVec[13]),
      .overVoltTrip(tripVec[12]), .driveTempTrip(tripVec[11]), .motorTempTrip(tripVec[10]),
      .overloadIntegralTrip(tripVec[9]), .overCurrentTrip(tripVec[8]), .shortCircuitTrip(tripVec[1]),
      .positionWrapTrip(tripVec[5]), .commErrorTrip(tripVec[4]), .controlErrorTrip(tripVec[3]),
      .linkErrorEvt(tripVec[0]), .faultReset(ctlVec[0]), .linkClearError(ctlVec[1]), .cmdErrPulse(ctlVec[2]),
      .cmdErrCode(cmdErrCode), .fnBusyCall(ctlVec[3]), .modeUpdInTransition(ctlVec[4]), .emcyValid(emcyValid),
      .emcyReady(emcyReady), .emcyCode(emcyCode), .emcyErrByte(emcyErrByte), .motionFaultFlags(motionFaultFlags),
      .summaryErrorByte(summaryErrorByte), .callWarnStatus(callWarnStatus));

   dem_fieldbus_master master_u (
      .clk(clk), .rst(rst), .emcyValid(emcyValid), .emcyCode(emcyCode), .emcyErrByte(emcyErrByte),
      .emcyReady(emcyReady), .stallCycles(stallCycles), .msgCount(msgCount), .lastCode(lastCode),
      .lastByte(lastByte));

   always #5 clk = ~clk;

   task automatic tally_and_finish();
      if (err_total == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Inputs move only at the falling edge so the rising edge always samples settled values.
   task automatic pulse(input logic [15:0] trip, input logic [4:0] ctl, input logic [1:0] cmd);
      @(negedge clk);
      tripVec = trip;
      ctlVec = ctl;
      cmdErrCode = dem_cmd_err_e'(cmd);
      @(negedge clk);
      tripVec = 16'h0000;
      ctlVec = 5'h00;
   endtask

   task automatic obj_access(input logic wr, input logic [15:0] idx, input logic [15:0] wdat,
                             input logic [15:0] rexp, input logic eexp);
      @(negedge clk);
      objWrite = wr;
      objRead = !wr;
      objIndex = idx;
      objWdata = wdat;
      @(negedge clk);
      objWrite = 1'b0;
      objRead = 1'b0;
      chk(objAck, 32'h1);
      chk(objErr, eexp);
      if (!wr) chk(objRdata, rexp);
   endtask

   // Waits for the master to take one more message, then compares what it took.
   task automatic expect_msg(input logic [15:0] code, input logic [7:0] errByte);
      int n;
      n = 0;
      while (msgCount === seenCount && n < 60) begin
         @(negedge clk);
         n++;
      end
      if (msgCount === seenCount) begin
         chk(msgCount, seenCount + 8'h01);
         tally_and_finish();
      end else begin
         seenCount = seenCount + 8'h01;
         chk(lastCode, code);
         chk(lastByte, errByte);
      end
   endtask

   task automatic wait_flags(input logic [15:0] exp);
      int n;
      n = 0;
      while (motionFaultFlags !== exp && n < 12) begin
         @(negedge clk);
         n++;
      end
      chk(motionFaultFlags, exp);
      if (motionFaultFlags !== exp) begin
         tally_and_finish();
      end
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {objWrite, objRead, objIndex, objWdata, tripVec, ctlVec} = '0;
      {negLimitIn, posLimitIn, setupInvalidIn} = 3'h0;
      enableIn = 1'b1;
      cmdErrCode = CMD_HOMING;
      stallCycles = 4'h2;
      seenCount = 8'h00;
      err_total = 0;
      comparisons = 0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      obj_access(1'b0, `DEM_IDX_SUMMARY, 16'h0000, 16'h0000, 1'b0);
      obj_access(1'b0, `DEM_IDX_FLAGS, 16'h0000, 16'h0000, 1'b0);
      obj_access(1'b0, `DEM_IDX_MASK, 16'h0000, 16'hffff, 1'b0);
      obj_access(1'b0, 16'h2002, 16'h0000, 16'h0000, 1'b1);
      obj_access(1'b1, `DEM_IDX_FLAGS, 16'h5555, 16'h0000, 1'b1);
      obj_access(1'b1, `DEM_IDX_SUMMARY, 16'h00ff, 16'h0000, 1'b1);
      obj_access(1'b0, `DEM_IDX_FLAGS, 16'h0000, 16'h0000, 1'b0);
      for (int i = 0; i < 14; i++) begin
         pulse(rows[i].trip & 16'hbfff, rows[i].trip[14] ? CE : 5'h00, rows[i].cmd);
         chk(motionFaultFlags, rows[i].trip);
         chk(summaryErrorByte, rows[i].sum);
         expect_msg(rows[i].code, rows[i].sum);
         pulse(16'h0000, FR, 2'h0);
         chk(motionFaultFlags, 16'h0000);
         expect_msg(`DEM_CODE_CLEARED, 8'h00);
      end
      // A masked bit still flags but stays silent on both edges.
      obj_access(1'b1, `DEM_IDX_MASK, 16'hfeff, 16'h0000, 1'b0);
      obj_access(1'b0, `DEM_IDX_MASK, 16'h0000, 16'hfeff, 1'b0);
      pulse(16'h0100, 5'h00, 2'h0);
      chk(motionFaultFlags, 16'h0100);
      repeat (10) @(negedge clk);
      pulse(16'h0000, FR, 2'h0);
      repeat (10) @(negedge clk);
      chk(msgCount, seenCount);
      obj_access(1'b1, `DEM_IDX_MASK, 16'hffff, 16'h0000, 1'b0);
      // Three trips at once against a slow master come out lowest bit first.
      stallCycles = 4'h6;
      pulse(16'h200a, 5'h00, 2'h0);
      expect_msg(16'hff11, 8'h01);
      expect_msg(16'hff13, 8'h01);
      expect_msg(16'hff1d, 8'h01);
      pulse(16'h0000, FR, 2'h0);
      for (int i = 0; i < 3; i++) expect_msg(`DEM_CODE_CLEARED, 8'h00);
      // Level flags follow their pins and ignore a fault reset.
      @(negedge clk);
      {enableIn, negLimitIn, posLimitIn, setupInvalidIn} = 4'h7;
      wait_flags(16'h80c4);
      expect_msg(16'hff12, 8'h01);
      expect_msg(16'hff16, 8'h01);
      expect_msg(16'hff17, 8'h01);
      expect_msg(16'hff1f, 8'h01);
      pulse(16'h0000, FR, 2'h0);
      chk(motionFaultFlags, 16'h80c4);
      {enableIn, negLimitIn, posLimitIn, setupInvalidIn} = 4'h8;
      wait_flags(16'h0000);
      for (int i = 0; i < 4; i++) expect_msg(`DEM_CODE_CLEARED, 8'h00);
      stallCycles = 4'h0;
      pulse(16'h0000, FB, 2'h0);
      chk(motionFaultFlags, 16'h4000);
      chk(callWarnStatus, 32'h1);
      expect_msg(16'hff1e, 8'h01);
      pulse(16'h0000, FR, 2'h0);
      chk(callWarnStatus, 32'h0);
      expect_msg(`DEM_CODE_CLEARED, 8'h00);
      pulse(16'h0000, MU, 2'h0);
      chk(motionFaultFlags, 16'h4000);
      expect_msg(16'hff1e, 8'h01);
      pulse(16'h0000, FR, 2'h0);
      expect_msg(`DEM_CODE_CLEARED, 8'h00);
      // The link clear-error request drops only the link flag.
      pulse(16'h0011, 5'h00, 2'h0);
      expect_msg(16'hff10, 8'h11);
      expect_msg(16'hff14, 8'h11);
      pulse(16'h0000, LC, 2'h0);
      chk(motionFaultFlags, 16'h0010);
      chk(summaryErrorByte, 8'h11);
      expect_msg(`DEM_CODE_CLEARED, 8'h11);
      // A second reset in mid-run brings flags and mask back to their reset values.
      obj_access(1'b1, `DEM_IDX_MASK, 16'h1234, 16'h0000, 1'b0);
      @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      seenCount = 8'h00;
      chk(motionFaultFlags, 16'h0000);
      obj_access(1'b0, `DEM_IDX_MASK, 16'h0000, 16'hffff, 1'b0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
